// ### logic/oag_pkg.sv
// Constants, enumerations and carrier structs for operand address generation.
// Assumes a single processor clock and an external decoder that names the mode.
package oag_pkg;

	// ------------------------------------------------------------
	// Widths and fixed figures
	// ------------------------------------------------------------
	localparam int          OAG_AW         = 16;
	localparam int          OAG_DW         = 8;
	localparam logic [15:0] OAG_REL_NEXT   = 16'h0002;
	localparam logic [16:0] OAG_IO_BLK_MAX = 17'h00100;
	localparam logic [16:0] OAG_BLK_MAX    = 17'h10000;
	localparam logic [16:0] OAG_CNT_ONE    = 17'h00001;
	localparam logic [15:0] OAG_PTR_STEP   = 16'h0001;
	localparam logic [9:0]  OAG_PAGE0_HI   = 10'h000;
	localparam logic [2:0]  OAG_PAGE0_LO   = 3'h0;
	localparam logic [7:0]  OAG_IO_HI      = 8'h00;
	localparam logic [7:0]  OAG_ZERO_B     = 8'h00;
	localparam logic [1:0]  OAG_NB0        = 2'h0;
	localparam logic [1:0]  OAG_NB1        = 2'h1;
	localparam logic [1:0]  OAG_NB2        = 2'h2;
	localparam int          OAG_RST_MSB    = 5;
	localparam int          OAG_RST_LSB    = 3;

	// ------------------------------------------------------------
	// Enumerations
	// ------------------------------------------------------------
	typedef enum logic [3:0] {
		OAG_M_IMM     = 4'h0,
		OAG_M_IMM_EXT = 4'h1,
		OAG_M_RESTART = 4'h2,
		OAG_M_REL     = 4'h3,
		OAG_M_EXT_JP  = 4'h4,
		OAG_M_EXT_MEM = 4'h5,
		OAG_M_IDX     = 4'h6,
		OAG_M_IND_JP  = 4'h7,
		OAG_M_IO_IMM  = 4'h8,
		OAG_M_IO_REG  = 4'h9,
		OAG_M_LOAD    = 4'hA,
		OAG_M_ALU     = 4'hB
	} oag_mode_t;

	typedef enum logic [1:0] {
		OAG_SEL_PTR    = 2'h0,
		OAG_SEL_FIRST  = 2'h1,
		OAG_SEL_SECOND = 2'h2
	} oag_sel_t;

	typedef enum logic [1:0] {
		OAG_ALU_ADD = 2'h0,
		OAG_ALU_AND = 2'h1,
		OAG_ALU_OR  = 2'h2,
		OAG_ALU_XOR = 2'h3
	} oag_alu_t;

	typedef enum logic [1:0] {
		OAG_B_MOVE   = 2'h0,
		OAG_B_SEARCH = 2'h1,
		OAG_B_IO     = 2'h2
	} oag_blk_t;

	// ------------------------------------------------------------
	// Carriers
	// ------------------------------------------------------------
	typedef struct packed {
		logic [15:0] op_addr;
		logic [15:0] pointer_register_pair;
		logic [15:0] first_index_register;
		logic [15:0] second_index_register;
		logic [7:0]  port_ptr;
		logic [7:0]  acc;
	} oag_regs_t;

	typedef struct packed {
		logic        valid;
		logic [15:0] addr;
		logic [15:0] value;
		logic        is_jump;
		logic        is_mem;
		logic        is_io;
		logic        acc_we;
		logic        dst_we;
	} oag_res_t;

	typedef struct packed {
		logic sign;
		logic zero;
		logic parity;
		logic carry;
	} oag_flags_t;

endpackage

// ### logic/oag_addsx.sv
// Adds a sign-extended displacement to a base address.
// Assumes the caller wants the sum to wrap at the address width.
module oag_addsx #(
	parameter int AW = 16,
	parameter int DW = 8
) (
	input  wire logic [AW-1:0] base,
	input  wire logic [DW-1:0] disp,
	output logic      [AW-1:0] sum
);

	// The carry out is dropped on purpose so the result always fits the bus.
	assign sum = base + {{(AW-DW){disp[DW-1]}}, disp};

endmodule

// ### logic/oag_top.sv
// Operand address generation, I/O port addressing and block engine.
// Assumes bytes arrive from program memory on the same clock as this logic.
//
// Functional notes
// - Immediate mode uses the byte after the opcode as the operand.
// - Immediate extended mode uses the next two bytes as a 16-bit operand.
// - First fetched byte is the low half, second byte the high half.
// - Restart jumps to page-zero address from opcode bits 5..3, three zero bits.
// - Relative jump adds signed displacement to opcode address plus two.
// - Relative displacement spans +127 to -128 from opcode address plus two.
// - Extended mode uses a 16-bit in-stream address as target or operand.
// - Indexed mode adds displacement to the selected index register.
// - Indexed displacement is sign-extended before the addition.
// - Forming an indexed address never changes the index register.
// - Displacement byte directly follows the opcode bytes.
// - I/O transactions put the port number on the low eight address bits.
// - Port number comes from the second byte or the port-pointer register.
// - Input data sets the flags, parity included, unless an ALU result sets them in the same cycle.
// - Block I/O moves up to 256 bytes to consecutive memory locations.
// - Block operations may be interrupted between elements.
// - Block search stops on a match or when the length runs out.
// - Loads write the destination only and leave the source untouched.
// - Indirect jumps load the program counter from pointer or index registers.
// - Arithmetic and logic results go to the accumulator and set the flags.
module oag_top (
	input  wire logic             clk,
	input  wire logic             reset_n,
	input  wire logic             start,
	input  oag_pkg::oag_mode_t    mode,
	input  wire logic [7:0]       opcode,
	input  oag_pkg::oag_sel_t     reg_sel,
	input  oag_pkg::oag_alu_t     alu_op,
	input  oag_pkg::oag_regs_t    regs,
	input  wire logic [7:0]       src_data,
	output logic                  start_ready,
	input  wire logic             byte_valid,
	input  wire logic [7:0]       byte_data,
	output logic                  byte_ready,
	output oag_pkg::oag_res_t     res,
	output oag_pkg::oag_flags_t   flags,
	input  wire logic             io_in_valid,
	input  wire logic [7:0]       io_in_data,
	input  wire logic             blk_start,
	input  oag_pkg::oag_blk_t     blk_kind,
	input  wire logic [15:0]      blk_count,
	input  wire logic [7:0]       blk_char,
	input  wire logic             irq_pending,
	output logic                  elem_req,
	output logic [15:0]           elem_addr,
	input  wire logic             elem_ack,
	input  wire logic [7:0]       elem_data,
	output logic                  blk_busy,
	output logic                  blk_done,
	output logic                  blk_found,
	output logic                  blk_intr,
	output logic [16:0]           blk_left
);
	import oag_pkg::*;

	// ------------------------------------------------------------
	// Instruction stream sequencer
	// ------------------------------------------------------------
	typedef enum logic [3:0] {
		S_IDLE = 4'h1,
		S_LO   = 4'h2,
		S_HI   = 4'h4,
		S_DONE = 4'h8
	} oag_st_t;

	oag_st_t    st_r,    st_nxt;
	oag_mode_t  mode_r,  mode_nxt;
	oag_sel_t   sel_r,   sel_nxt;
	oag_alu_t   alu_r,   alu_nxt;
	oag_regs_t  regs_r,  regs_nxt;
	logic [7:0] op_r,    op_nxt;
	logic [7:0] src_r,   src_nxt;
	logic [7:0] lo_r,    lo_nxt;
	logic [7:0] hi_r,    hi_nxt;
	logic [1:0] need_r,  need_nxt;
	oag_res_t   res_r,   res_nxt;
	oag_flags_t flg_r,   flg_nxt;
	logic [15:0] rel_sum;
	logic [15:0] idx_sum;
	logic [15:0] idx_base;
	logic [15:0] rel_base;
	logic [8:0]  alu_sum;
	logic [7:0]  alu_val;

	function automatic logic [1:0] f_need(input oag_mode_t m);
		case (m)
			OAG_M_IMM_EXT, OAG_M_EXT_JP, OAG_M_EXT_MEM: f_need = OAG_NB2;
			OAG_M_IMM, OAG_M_REL, OAG_M_IDX, OAG_M_IO_IMM, OAG_M_ALU: f_need = OAG_NB1;
			default: f_need = OAG_NB0;
		endcase
	endfunction

	function automatic oag_flags_t f_flags(input logic [7:0] v, input logic c);
		oag_flags_t f;
		f.sign   = v[7];
		f.zero   = (v == OAG_ZERO_B);
		f.parity = ~^v;
		f.carry  = c;
		return f;
	endfunction

	// Index value only feeds the adder; nothing here ever writes it back.
	assign idx_base = (sel_r == OAG_SEL_SECOND) ? regs_r.second_index_register
	                                            : regs_r.first_index_register;
	assign rel_base = regs_r.op_addr + OAG_REL_NEXT;

	oag_addsx #(.AW(OAG_AW), .DW(OAG_DW)) u_rel (
		.base (rel_base),
		.disp (lo_r),
		.sum  (rel_sum)
	);

	oag_addsx #(.AW(OAG_AW), .DW(OAG_DW)) u_idx (
		.base (idx_base),
		.disp (lo_r),
		.sum  (idx_sum)
	);

	always_comb begin
		alu_sum = {1'b0, regs_r.acc} + {1'b0, lo_r};
		case (alu_r)
			OAG_ALU_AND: alu_val = regs_r.acc & lo_r;
			OAG_ALU_OR:  alu_val = regs_r.acc | lo_r;
			OAG_ALU_XOR: alu_val = regs_r.acc ^ lo_r;
			default:     alu_val = alu_sum[7:0];
		endcase
	end

	always_comb begin
		st_nxt   = st_r;
		mode_nxt = mode_r;
		sel_nxt  = sel_r;
		alu_nxt  = alu_r;
		regs_nxt = regs_r;
		op_nxt   = op_r;
		src_nxt  = src_r;
		lo_nxt   = lo_r;
		hi_nxt   = hi_r;
		need_nxt = need_r;
		res_nxt  = '0;
		flg_nxt  = flg_r;
		if (io_in_valid) begin
			flg_nxt = f_flags(io_in_data, flg_r.carry);
		end
		case (st_r)
			S_IDLE: begin
				if (start) begin
					mode_nxt = mode;
					sel_nxt  = reg_sel;
					alu_nxt  = alu_op;
					regs_nxt = regs;
					op_nxt   = opcode;
					src_nxt  = src_data;
					need_nxt = f_need(mode);
					st_nxt   = (f_need(mode) == OAG_NB0) ? S_DONE : S_LO;
				end
			end
			S_LO: begin
				if (byte_valid) begin
					lo_nxt = byte_data;
					st_nxt = (need_r == OAG_NB2) ? S_HI : S_DONE;
				end
			end
			S_HI: begin
				if (byte_valid) begin
					hi_nxt = byte_data;
					st_nxt = S_DONE;
				end
			end
			S_DONE: begin
				st_nxt = S_IDLE;
				res_nxt.valid = 1'b1;
				case (mode_r)
					OAG_M_IMM:     res_nxt.value = {OAG_ZERO_B, lo_r};
					OAG_M_IMM_EXT: res_nxt.value = {hi_r, lo_r};
					OAG_M_RESTART: begin
						res_nxt.addr    = {OAG_PAGE0_HI, op_r[OAG_RST_MSB:OAG_RST_LSB], OAG_PAGE0_LO};
						res_nxt.is_jump = 1'b1;
					end
					OAG_M_REL: begin
						res_nxt.addr    = rel_sum;
						res_nxt.is_jump = 1'b1;
					end
					OAG_M_EXT_JP: begin
						res_nxt.addr    = {hi_r, lo_r};
						res_nxt.is_jump = 1'b1;
					end
					OAG_M_EXT_MEM: begin
						res_nxt.addr   = {hi_r, lo_r};
						res_nxt.is_mem = 1'b1;
					end
					OAG_M_IDX: begin
						res_nxt.addr   = idx_sum;
						res_nxt.is_mem = 1'b1;
					end
					OAG_M_IND_JP: begin
						res_nxt.is_jump = 1'b1;
						case (sel_r)
							OAG_SEL_FIRST:  res_nxt.addr = regs_r.first_index_register;
							OAG_SEL_SECOND: res_nxt.addr = regs_r.second_index_register;
							default:        res_nxt.addr = regs_r.pointer_register_pair;
						endcase
					end
					OAG_M_IO_IMM: begin
						res_nxt.addr  = {OAG_IO_HI, lo_r};
						res_nxt.is_io = 1'b1;
					end
					OAG_M_IO_REG: begin
						res_nxt.addr  = {OAG_IO_HI, regs_r.port_ptr};
						res_nxt.is_io = 1'b1;
					end
					OAG_M_LOAD: begin
						// Only the destination strobe exists; the source has no write path.
						res_nxt.value  = {OAG_ZERO_B, src_r};
						res_nxt.dst_we = 1'b1;
					end
					OAG_M_ALU: begin
						res_nxt.value  = {OAG_ZERO_B, alu_val};
						res_nxt.acc_we = 1'b1;
						flg_nxt = f_flags(alu_val, (alu_r == OAG_ALU_ADD) & alu_sum[8]);
					end
					default: res_nxt.valid = 1'b1;
				endcase
			end
			default: st_nxt = S_IDLE;
		endcase
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			st_r   <= S_IDLE;
			mode_r <= OAG_M_IMM;
			sel_r  <= OAG_SEL_PTR;
			alu_r  <= OAG_ALU_ADD;
			regs_r <= '0;
			op_r   <= '0;
			src_r  <= '0;
			lo_r   <= '0;
			hi_r   <= '0;
			need_r <= OAG_NB0;
			res_r  <= '0;
			flg_r  <= '0;
		end else begin
			st_r   <= st_nxt;
			mode_r <= mode_nxt;
			sel_r  <= sel_nxt;
			alu_r  <= alu_nxt;
			regs_r <= regs_nxt;
			op_r   <= op_nxt;
			src_r  <= src_nxt;
			lo_r   <= lo_nxt;
			hi_r   <= hi_nxt;
			need_r <= need_nxt;
			res_r  <= res_nxt;
			flg_r  <= flg_nxt;
		end
	end

	assign start_ready = (st_r == S_IDLE);
	assign byte_ready  = (st_r == S_LO) || (st_r == S_HI);
	assign res         = res_r;
	assign flags       = flg_r;

	// ------------------------------------------------------------
	// Block engine
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		B_IDLE = 3'h1,
		B_REQ  = 3'h2,
		B_END  = 3'h4
	} oag_bst_t;

	oag_bst_t    bst_r,   bst_nxt;
	oag_blk_t    bkind_r, bkind_nxt;
	logic [16:0] cnt_r,   cnt_nxt;
	logic [15:0] ptr_r,   ptr_nxt;
	logic [7:0]  chr_r,   chr_nxt;
	logic        fnd_r,   fnd_nxt;
	logic        int_r,   int_nxt;
	logic        dn_r,    dn_nxt;

	always_comb begin
		bst_nxt   = bst_r;
		bkind_nxt = bkind_r;
		cnt_nxt   = cnt_r;
		ptr_nxt   = ptr_r;
		chr_nxt   = chr_r;
		fnd_nxt   = fnd_r;
		int_nxt   = int_r;
		dn_nxt    = 1'b0;
		case (bst_r)
			B_IDLE: begin
				if (blk_start) begin
					bkind_nxt = blk_kind;
					ptr_nxt   = regs.pointer_register_pair;
					chr_nxt   = blk_char;
					fnd_nxt   = 1'b0;
					int_nxt   = 1'b0;
					bst_nxt   = B_REQ;
					// A zero count means the full span, as a down-counter wraps to it.
					if (blk_kind == OAG_B_IO) begin
						cnt_nxt = (blk_count[7:0] == OAG_ZERO_B) ? OAG_IO_BLK_MAX
						                                           : {9'h000, blk_count[7:0]};
					end else begin
						cnt_nxt = (blk_count == 16'h0000) ? OAG_BLK_MAX : {1'b0, blk_count};
					end
				end
			end
			B_REQ: begin
				if (elem_ack) begin
					cnt_nxt = cnt_r - OAG_CNT_ONE;
					ptr_nxt = ptr_r + OAG_PTR_STEP;
					if ((bkind_r == OAG_B_SEARCH) && (elem_data == chr_r)) begin
						fnd_nxt = 1'b1;
						bst_nxt = B_END;
					end else if (cnt_r == OAG_CNT_ONE) begin
						bst_nxt = B_END;
					end else if (irq_pending) begin
						int_nxt = 1'b1;
						bst_nxt = B_END;
					end
				end
			end
			B_END: begin
				dn_nxt  = 1'b1;
				bst_nxt = B_IDLE;
			end
			default: bst_nxt = B_IDLE;
		endcase
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			bst_r   <= B_IDLE;
			bkind_r <= OAG_B_MOVE;
			cnt_r   <= '0;
			ptr_r   <= '0;
			chr_r   <= '0;
			fnd_r   <= 1'b0;
			int_r   <= 1'b0;
			dn_r    <= 1'b0;
		end else begin
			bst_r   <= bst_nxt;
			bkind_r <= bkind_nxt;
			cnt_r   <= cnt_nxt;
			ptr_r   <= ptr_nxt;
			chr_r   <= chr_nxt;
			fnd_r   <= fnd_nxt;
			int_r   <= int_nxt;
			dn_r    <= dn_nxt;
		end
	end

	assign elem_req  = (bst_r == B_REQ);
	assign elem_addr = ptr_r;
	assign blk_busy  = (bst_r != B_IDLE);
	assign blk_done  = dn_r;
	assign blk_found = fnd_r;
	assign blk_intr  = int_r;
	assign blk_left  = cnt_r;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	property p_imm_ext;
		@(posedge clk) disable iff (!reset_n)
		(st_r == S_HI && byte_valid) ##1 (st_r == S_DONE)
		|=> (mode_r != OAG_M_IMM_EXT) || (res.value == {$past(byte_data, 2), $past(lo_r, 1)});
	endproperty
	a_imm_ext: assert property (p_imm_ext) else $error("two-byte operand order wrong");

	property p_restart;
		@(posedge clk) disable iff (!reset_n)
		(st_r == S_DONE && mode_r == OAG_M_RESTART)
		|=> res.valid && res.is_jump && (res.addr == {10'h000, $past(op_r[5:3]), 3'h0});
	endproperty
	a_restart: assert property (p_restart) else $error("restart target wrong");

	property p_rel;
		@(posedge clk) disable iff (!reset_n)
		(st_r == S_DONE && mode_r == OAG_M_REL)
		|=> res.addr == 16'($past(regs_r.op_addr) + 16'h0002 + {{8{$past(lo_r[7])}}, $past(lo_r)});
	endproperty
	a_rel: assert property (p_rel) else $error("relative target wrong");

	property p_idx;
		@(posedge clk) disable iff (!reset_n)
		(st_r == S_DONE && mode_r == OAG_M_IDX && sel_r == OAG_SEL_SECOND)
		|=> res.is_mem && res.addr == 16'($past(regs_r.second_index_register) + {{8{$past(lo_r[7])}}, $past(lo_r)});
	endproperty
	a_idx: assert property (p_idx) else $error("indexed address wrong");

	property p_io_port;
		@(posedge clk) disable iff (!reset_n)
		(st_r == S_DONE && mode_r == OAG_M_IO_REG) |=> res.is_io && res.addr == {8'h00, $past(regs_r.port_ptr)};
	endproperty
	a_io_port: assert property (p_io_port) else $error("port number not on low address");

	property p_in_flags;
		@(posedge clk) disable iff (!reset_n)
		(io_in_valid && st_r != S_DONE) |=> flags.parity == ~^$past(io_in_data) && flags.zero == ($past(io_in_data) == 8'h00);
	endproperty
	a_in_flags: assert property (p_in_flags) else $error("input flags wrong");

	property p_io_256;
		@(posedge clk) disable iff (!reset_n)
		(bst_r == B_IDLE && blk_start && blk_kind == OAG_B_IO && blk_count[7:0] == 8'h00) |=> blk_left == 17'h00100;
	endproperty
	a_io_256: assert property (p_io_256) else $error("block I/O length wrong");

	property p_intr;
		@(posedge clk) disable iff (!reset_n)
		(elem_req && elem_ack && irq_pending && cnt_r != 17'h00001 && !(bkind_r == OAG_B_SEARCH && elem_data == chr_r))
		|=> blk_intr && !elem_req ##1 blk_done ##1 !blk_busy;
	endproperty
	a_intr: assert property (p_intr) else $error("block not interrupted");

	property p_found;
		@(posedge clk) disable iff (!reset_n)
		(elem_req && elem_ack && bkind_r == OAG_B_SEARCH && elem_data == chr_r) |=> blk_found && !blk_intr && !elem_req;
	endproperty
	a_found: assert property (p_found) else $error("search did not stop on match");

endmodule

// ### verification/oag_mem_model.sv
// Behavioural program memory and block memory facing the operand address generator.
// Assumes the bench pushes instruction bytes and block data follows a fixed address pattern.
module oag_mem_model (
	input  wire logic        clk,
	input  wire logic        slow,
	input  wire logic        byte_ready,
	output logic             byte_valid,
	output logic [7:0]       byte_data,
	input  wire logic        elem_req,
	input  wire logic [15:0] elem_addr,
	output logic             elem_ack,
	output logic [7:0]       elem_data
);
	timeunit 1ns;
	timeprecision 100ps;

	// ------------------------------------------------------------
	// Stream and element answers
	// ------------------------------------------------------------
	logic [7:0] q[$];

	task automatic push(input logic [7:0] b);
		q.push_back(b);
	endtask

	initial begin
		byte_valid = 1'b0;
		byte_data  = 8'h00;
		elem_ack   = 1'b0;
		elem_data  = 8'h00;
	end

	// Idle data lines toggle, so a design that samples them outside a handshake sees noise.
	always @(posedge clk) begin
		logic tk;
		tk = byte_valid & byte_ready;
		#1;
		if (tk)
			void'(q.pop_front());
		byte_valid = (q.size() != 0);
		byte_data  = byte_valid ? q[0] : ~byte_data;
		elem_ack   = elem_req & (~slow | ~elem_ack);
		elem_data  = elem_ack ? (elem_addr[7:0] ^ 8'h5A) : ~elem_data;
	end
endmodule

// ### verification/oag_testbench.sv
// Self-checking bench for the operand address generator and its block engine.
// Assumes the memory model of oag_mem_model.sv and the design package.
module testbench;
	timeunit 1ns;
	timeprecision 100ps;
	import oag_pkg::*;

	`define CHK(g, x, m) begin n_compared++; if ((g) !== (x)) begin err_total++; $display("FAIL %0t %s", $time, m); end end

	typedef struct packed {
		logic [16:0] n;
		logic        f;
		logic        i;
		logic [16:0] left;
	} oag_bexp_t;

	// ------------------------------------------------------------
	// Signals and instances
	// ------------------------------------------------------------
	logic        clk = 1'b0, reset_n = 1'b0, start = 1'b0, io_in_valid = 1'b0, blk_start = 1'b0;
	logic        irq_pending = 1'b0, slow = 1'b0;
	logic [7:0]  opcode = 8'h00, src_data = 8'h00, io_in_data = 8'h00, blk_char = 8'h00;
	logic [15:0] blk_count = 16'h0000;
	oag_mode_t   mode = OAG_M_IMM;
	oag_sel_t    reg_sel = OAG_SEL_PTR;
	oag_alu_t    alu_op = OAG_ALU_ADD;
	oag_regs_t   regs = '0;
	oag_blk_t    blk_kind = OAG_B_MOVE;
	logic        start_ready, byte_valid, byte_ready, elem_req, elem_ack, blk_busy, blk_done, blk_found, blk_intr, c;
	logic [7:0]  byte_data, elem_data, a, b, d, r;
	logic [15:0] elem_addr, bbase, w, x;
	logic [16:0] blk_left;
	oag_res_t    res, e, k, em, km;
	oag_res_t    exp_q[$], msk_q[$];
	oag_flags_t  flags, f;
	oag_bexp_t   bq[$], bm;
	int          err_total, n_compared, acks, seed;

	oag_top uut (.clk, .reset_n, .start, .mode, .opcode, .reg_sel, .alu_op, .regs, .src_data, .start_ready,
		.byte_valid, .byte_data, .byte_ready, .res, .flags, .io_in_valid, .io_in_data, .blk_start, .blk_kind,
		.blk_count, .blk_char, .irq_pending, .elem_req, .elem_addr, .elem_ack, .elem_data, .blk_busy, .blk_done,
		.blk_found, .blk_intr, .blk_left);
	oag_mem_model pm (.clk, .slow, .byte_ready, .byte_valid, .byte_data, .elem_req, .elem_addr, .elem_ack,
		.elem_data);

	always #20 clk = ~clk;

	// ------------------------------------------------------------
	// Tasks and monitors
	// ------------------------------------------------------------
	function automatic oag_flags_t fl(logic [7:0] v, logic cy);
		return {v[7], v == 8'h00, ~^v, cy};
	endfunction

	task automatic wrap_up();
		$display("compared %0d mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// Only fields whose mask bit is set are compared, so unlisted strobes stay free.
	task automatic ex(logic [15:0] ad, logic [15:0] v, logic [15:0] ma, logic [15:0] mv, logic [4:0] fb);
		e = {1'b0, ad, v, fb};
		k = {1'b0, ma, mv, fb};
	endtask

	task automatic go(oag_mode_t m, logic [1:0] nb, logic [15:0] bw);
		int n;
		if (nb != 2'h0)
			pm.push(bw[7:0]);
		if (nb == 2'h2)
			pm.push(bw[15:8]);
		mode = m;
		start = 1'b1;
		exp_q.push_back(e);
		msk_q.push_back(k);
		@(posedge clk);
		#1 start = 1'b0;
		n = 0;
		while (start_ready !== 1'b1 && n < 50) begin
			@(posedge clk);
			#1 n++;
		end
		`CHK(n < 50, 1'b1, "sequencer hang")
	endtask

	task automatic blk(oag_blk_t kd, logic [15:0] cnt, logic [7:0] ch, logic irq, oag_bexp_t xb);
		int n;
		bbase = regs.pointer_register_pair;
		acks = 0;
		bq.push_back(xb);
		blk_kind = kd;
		blk_count = cnt;
		blk_char = ch;
		irq_pending = irq;
		blk_start = 1'b1;
		@(posedge clk);
		#1 blk_start = 1'b0;
		n = 0;
		while (blk_busy !== 1'b0 && n < 2000) begin
			@(posedge clk);
			#1 n++;
		end
		// The done pulse is judged one edge later, so the element tally must survive that edge.
		@(posedge clk);
		#1 irq_pending = 1'b0;
		`CHK(n < 2000, 1'b1, "block hang")
	endtask

	always @(posedge clk) if (res.valid === 1'b1) begin
		em = exp_q.pop_front();
		km = msk_q.pop_front();
		`CHK(res & km, em & km, "result fields")
	end

	always @(posedge clk) if (elem_req === 1'b1 && elem_ack === 1'b1) begin
		`CHK(elem_addr, 16'(bbase + acks), "element address")
		acks++;
	end

	always @(posedge clk) if (blk_done === 1'b1) begin
		bm = bq.pop_front();
		`CHK({17'(acks), blk_found, blk_intr, blk_left}, bm, "block end")
	end

	// The whole run needs well under a thousand cycles, so ten thousand leaves ample margin.
	initial begin
		#400000;
		err_total++;
		wrap_up();
	end

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	initial begin
		seed = 48228;
		repeat (4) @(posedge clk);
		#1 reset_n = 1'b1;
		regs = {16'($random(seed)), 16'($random(seed)), 16'($random(seed)), 16'($random(seed)), 8'($random(seed)),
			8'($random(seed))};
		b = 8'($random(seed));
		w = 16'($random(seed));
		ex(16'h0000, {8'h00, b}, 16'h0000, 16'h00FF, 5'h00);
		go(OAG_M_IMM, 2'h1, {8'h00, b});
		ex(16'h0000, w, 16'h0000, 16'hFFFF, 5'h00);
		go(OAG_M_IMM_EXT, 2'h2, w);
		ex(w, 16'h0000, 16'hFFFF, 16'h0000, 5'h10);
		go(OAG_M_EXT_JP, 2'h2, w);
		ex(~w, 16'h0000, 16'hFFFF, 16'h0000, 5'h08);
		go(OAG_M_EXT_MEM, 2'h2, ~w);
		ex({8'h00, b}, 16'h0000, 16'hFFFF, 16'h0000, 5'h04);
		go(OAG_M_IO_IMM, 2'h1, {8'h00, b});
		ex({8'h00, regs.port_ptr}, 16'h0000, 16'hFFFF, 16'h0000, 5'h04);
		go(OAG_M_IO_REG, 2'h0, 16'h0000);
		src_data = ~b;
		ex(16'h0000, {8'h00, ~b}, 16'h0000, 16'h00FF, 5'h01);
		go(OAG_M_LOAD, 2'h0, 16'h0000);
		for (int i = 0; i < 8; i++) begin
			opcode = {2'h3, 3'(i), 3'h7};
			ex({10'h000, 3'(i), 3'h0}, 16'h0000, 16'hFFFF, 16'h0000, 5'h10);
			go(OAG_M_RESTART, 2'h0, 16'h0000);
		end
		for (int i = 0; i < 6; i++) begin
			d = (i == 0) ? 8'h7F : (i == 1) ? 8'h80 : 8'($random(seed));
			regs.op_addr = (i == 0) ? 16'hFFFE : 16'($random(seed));
			ex(regs.op_addr + 16'h0002 + {{8{d[7]}}, d}, 16'h0000, 16'hFFFF, 16'h0000, 5'h10);
			go(OAG_M_REL, 2'h1, {8'h00, d});
			reg_sel = i[0] ? OAG_SEL_SECOND : OAG_SEL_FIRST;
			regs.first_index_register = (i == 0) ? 16'hFFF0 : 16'($random(seed));
			x = i[0] ? regs.second_index_register : regs.first_index_register;
			ex(x + {{8{d[7]}}, d}, 16'h0000, 16'hFFFF, 16'h0000, 5'h08);
			go(OAG_M_IDX, 2'h1, {8'h00, d});
		end
		for (int i = 0; i < 3; i++) begin
			reg_sel = oag_sel_t'(2'(i));
			x = (i == 0) ? regs.pointer_register_pair : (i == 1) ? regs.first_index_register : regs.second_index_register;
			ex(x, 16'h0000, 16'hFFFF, 16'h0000, 5'h10);
			go(OAG_M_IND_JP, 2'h0, 16'h0000);
		end
		$display("test sequencer done");
		for (int i = 0; i < 8; i++) begin
			a = (i < 4) ? 8'hFF : 8'($random(seed));
			b = (i < 4) ? 8'h01 : 8'($random(seed));
			alu_op = oag_alu_t'(2'(i));
			regs.acc = a;
			case (alu_op)
				OAG_ALU_ADD: {c, r} = {1'b0, a} + {1'b0, b};
				OAG_ALU_AND: {c, r} = {1'b0, a & b};
				OAG_ALU_OR:  {c, r} = {1'b0, a | b};
				default:     {c, r} = {1'b0, a ^ b};
			endcase
			ex(16'h0000, {8'h00, r}, 16'h0000, 16'h00FF, 5'h02);
			go(OAG_M_ALU, 2'h1, {8'h00, b});
			@(posedge clk);
			#1 `CHK(flags, fl(r, c), "alu flags")
		end
		for (int i = 0; i < 6; i++) begin
			d = (i == 0) ? 8'h00 : (i == 1) ? 8'h80 : 8'($random(seed));
			io_in_data = d;
			io_in_valid = 1'b1;
			@(posedge clk);
			#1 io_in_valid = 1'b0;
			f = fl(d, 1'b0);
			`CHK(flags[3:1], f[3:1], "input flags")
		end
		$display("test alu and input done");
		regs.pointer_register_pair = 16'h1230;
		blk(OAG_B_MOVE, 16'h0003, 8'h00, 1'b0, {17'h00003, 2'h0, 17'h00000});
		blk(OAG_B_SEARCH, 16'h0004, 8'h68, 1'b0, {17'h00003, 2'h2, 17'h00001});
		blk(OAG_B_SEARCH, 16'h0000, 8'h68, 1'b0, {17'h00003, 2'h2, 17'h0FFFD});
		blk(OAG_B_SEARCH, 16'h0004, 8'h00, 1'b0, {17'h00004, 2'h0, 17'h00000});
		blk(OAG_B_SEARCH, 16'h0004, 8'h00, 1'b1, {17'h00001, 2'h1, 17'h00003});
		blk(OAG_B_MOVE, 16'h0005, 8'h00, 1'b1, {17'h00001, 2'h1, 17'h00004});
		blk(OAG_B_MOVE, 16'h0004, 8'h00, 1'b0, {17'h00004, 2'h0, 17'h00000});
		slow = 1'b1;
		blk(OAG_B_IO, 16'h0000, 8'h00, 1'b0, {17'h00100, 2'h0, 17'h00000});
		blk(OAG_B_IO, 16'h0102, 8'h00, 1'b0, {17'h00002, 2'h0, 17'h00000});
		$display("test block done");
		wrap_up();
	end
endmodule
